// *** hdl/board_interrupt_router.sv ***
`timescale 1ns/1ps
`include "irq_router_map.svh"
// How it works
// - Serial/printer controller request can raise NMI when selected.
// - Interval timer request can raise NMI when selected.
// - Software select register picks serial and/or timer source for NMI.
// - Bus timeout can raise NMI when enabled.
// - Expansion connector interrupt can raise NMI when enabled.
// - ROM-emulation connector NMI pin always raises NMI.
// - ISA host request always raises NMI.
// - Push switch raises NMI.
// - Mask bit 1 blocks NMI output, 0 releases it.
// - NMI status port shows which sources are pending.
// - First maskable output from serial channel one or printer, selectable.
// - ISA host can assert first maskable output.
// - Timer request drives second maskable output when selected.
// - Bus timeout drives second maskable output when enabled.
// - Each maskable output has its own mask bit, 1 blocks.
// - Each maskable output has its own status port.
// - Bus cycle busy 1024 clocks declares timeout and forces completion.
// - Timeout lights LED; a clear-port write clears LED and requests unless a timeout lands in the same cycle.
// - Expansion interrupt input is active low, feeds NMI and own pin.
module board_interrupt_router
    import irq_router_pkg::*;
#(
    parameter int TIMEOUT_LIMIT = `TIMEOUT_CLOCKS
) (
    input wire logic clk_i,                     // 20 MHz system clock
    input wire logic rstn_i,                    // Sync reset, active low
    input wire logic [7:0] addr_i,              // Register address
    input wire logic [7:0] wdata_i,             // Write data
    input wire logic wr_i,                      // Write strobe
    input wire logic rd_i,                      // Read strobe
    output logic [7:0] rdata_o,                 // Read data, cycle after strobe
    input wire logic serial_channel_one_i,      // Serial channel one request, high
    input wire logic printer_irq_i,             // Printer port request, high
    input wire logic timer_irq_i,               // Interval timer request, high
    input wire logic expansion_connector_irq_n_i, // Expansion request, low
    input wire logic rom_emulation_connector_nmi_i, // ROM-emulation NMI pin, high
    input wire logic host_nmi_i,                // ISA host NMI request, high
    input wire logic host_first_maskable_irq_i,               // ISA host maskable request, high
    input wire logic nonmaskable_push_switch_i, // Push switch, high while pressed
    input wire logic bus_cycle_busy_i,          // External bus cycle in progress
    output logic bus_force_ready_o,             // Forced completion of cycle
    output logic nmi_o,                         // Processor NMI request
    output logic first_maskable_irq_o,          // Processor first maskable request
    output logic second_maskable_irq_o,         // Processor second maskable request
    output logic expansion_irq_pin_o,           // Separate processor pin, high active
    output logic timeout_indicator_led_o        // Timeout LED, lit when high
);
    // Every external source is asynchronous to clk_i
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    wire [NSYNC-1:0] raw_in = {bus_cycle_busy_i, nonmaskable_push_switch_i, host_first_maskable_irq_i,
        host_nmi_i, rom_emulation_connector_nmi_i, !expansion_connector_irq_n_i,
        timer_irq_i, serial_channel_one_i | printer_irq_i};
    logic printer_s1_reg;
    logic printer_s2_reg;
    logic ch1_s1_reg;
    logic ch1_s2_reg;

    always_ff @(posedge clk_i) begin
        sync1_reg <= raw_in;
        sync2_reg <= sync1_reg;
        printer_s1_reg <= printer_irq_i;
        printer_s2_reg <= printer_s1_reg;
        ch1_s1_reg <= serial_channel_one_i;
        ch1_s2_reg <= ch1_s1_reg;
    end

    wire serial_s = sync2_reg[0];
    wire timer_s = sync2_reg[1];
    wire exp_s = sync2_reg[2];
    wire romem_s = sync2_reg[3];
    wire host_nmi_s = sync2_reg[4];
    wire host_first_maskable_irq_s = sync2_reg[5];
    wire switch_s = sync2_reg[6];
    wire busy_s = sync2_reg[7];

    // Control registers
    reg_byte_t mask_reg;
    reg_byte_t nmi_sel_reg;
    reg_byte_t first_maskable_irq_sel_reg;
    reg_byte_t second_maskable_irq_sel_reg;
    logic timeout_reg;
    reg_byte_t rdata_reg;
    reg_byte_t rdata_next;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        return a == target;
    endfunction : hit

    wire wr_mask = wr_i && hit(addr_i, `REG_MASK_ADDR);
    wire wr_nmi_sel = wr_i && hit(addr_i, `REG_NMI_SEL_ADDR);
    wire wr_first_maskable_irq_sel = wr_i && hit(addr_i, `REG_FIRST_MASKABLE_IRQ_SEL_ADDR);
    wire wr_second_maskable_irq_sel = wr_i && hit(addr_i, `REG_SECOND_MASKABLE_IRQ_SEL_ADDR);
    wire wr_to_clear = wr_i && hit(addr_i, `REG_TO_CLEAR_ADDR);

    // Timeout watch on the synchronised busy level
    timeout_if tif ();
    assign tif.cycle_busy = busy_s;
    assign tif.clear = wr_to_clear;

    bus_timeout #(
        .LIMIT(TIMEOUT_LIMIT)
    ) u_timeout (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .tif(tif)
    );

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            mask_reg <= `MASK_RESET;
            nmi_sel_reg <= `NMI_SEL_RESET;
            first_maskable_irq_sel_reg <= `FIRST_MASKABLE_IRQ_SEL_RESET;
            second_maskable_irq_sel_reg <= `SECOND_MASKABLE_IRQ_SEL_RESET;
            timeout_reg <= 1'b0;
        end else begin
            if (wr_mask) begin
                mask_reg <= wdata_i & 8'h07;
            end
            if (wr_nmi_sel) begin
                nmi_sel_reg <= wdata_i & 8'h0f;
            end
            if (wr_first_maskable_irq_sel) begin
                first_maskable_irq_sel_reg <= wdata_i & 8'h03;
            end
            if (wr_second_maskable_irq_sel) begin
                second_maskable_irq_sel_reg <= wdata_i & 8'h03;
            end
            // A timeout in the same cycle as the clear wins
            if (tif.timeout_pulse) begin
                timeout_reg <= 1'b1;
            end else if (wr_to_clear) begin
                timeout_reg <= 1'b0;
            end
        end
    end

    // Status reflects pending sources regardless of mask, so masked requests stay visible
    wire ch1_s = ch1_s2_reg;
    wire prn_s = printer_s2_reg;
    wire [7:0] nmi_status = {1'b0,
        switch_s,
        host_nmi_s,
        romem_s,
        exp_s & nmi_sel_reg[`NMI_SEL_EXP_BIT],
        timeout_reg & nmi_sel_reg[`NMI_SEL_TIMEOUT_BIT],
        timer_s & nmi_sel_reg[`NMI_SEL_TIMER_BIT],
        serial_s & nmi_sel_reg[`NMI_SEL_SERIAL_BIT]};
    wire [7:0] first_maskable_irq_status = {5'h00,
        host_first_maskable_irq_s,
        prn_s & first_maskable_irq_sel_reg[`FIRST_MASKABLE_IRQ_SEL_PRN_BIT],
        ch1_s & first_maskable_irq_sel_reg[`FIRST_MASKABLE_IRQ_SEL_CH1_BIT]};
    wire [7:0] second_maskable_irq_status = {6'h00,
        timeout_reg & second_maskable_irq_sel_reg[`SECOND_MASKABLE_IRQ_SEL_TIMEOUT_BIT],
        timer_s & second_maskable_irq_sel_reg[`SECOND_MASKABLE_IRQ_SEL_TIMER_BIT]};

    wire nmi_next = (|nmi_status) & !mask_reg[`MASK_NMI_BIT];
    wire first_maskable_irq_next = (|first_maskable_irq_status) & !mask_reg[`MASK_FIRST_MASKABLE_IRQ_BIT];
    wire second_maskable_irq_next = (|second_maskable_irq_status) & !mask_reg[`MASK_SECOND_MASKABLE_IRQ_BIT];

    always_comb begin
        case (addr_i)
            `REG_MASK_ADDR: rdata_next = mask_reg;
            `REG_NMI_SEL_ADDR: rdata_next = nmi_sel_reg;
            `REG_FIRST_MASKABLE_IRQ_SEL_ADDR: rdata_next = first_maskable_irq_sel_reg;
            `REG_SECOND_MASKABLE_IRQ_SEL_ADDR: rdata_next = second_maskable_irq_sel_reg;
            `REG_NMI_STAT_ADDR: rdata_next = nmi_status;
            `REG_FIRST_MASKABLE_IRQ_STAT_ADDR: rdata_next = first_maskable_irq_status;
            `REG_SECOND_MASKABLE_IRQ_STAT_ADDR: rdata_next = second_maskable_irq_status;
            `REG_TO_CLEAR_ADDR: rdata_next = {7'h00, timeout_reg};
            default: rdata_next = 8'h00;
        endcase
    end

    logic nmi_reg;
    logic first_maskable_irq_reg;
    logic second_maskable_irq_reg;
    logic exp_pin_reg;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_reg <= 8'h00;
            nmi_reg <= 1'b0;
            first_maskable_irq_reg <= 1'b0;
            second_maskable_irq_reg <= 1'b0;
            exp_pin_reg <= 1'b0;
        end else begin
            rdata_reg <= rd_i ? rdata_next : 8'h00;
            nmi_reg <= nmi_next;
            first_maskable_irq_reg <= first_maskable_irq_next;
            second_maskable_irq_reg <= second_maskable_irq_next;
            exp_pin_reg <= exp_s;
        end
    end

    assign rdata_o = rdata_reg;
    assign nmi_o = nmi_reg;
    assign first_maskable_irq_o = first_maskable_irq_reg;
    assign second_maskable_irq_o = second_maskable_irq_reg;
    assign expansion_irq_pin_o = exp_pin_reg;
    assign timeout_indicator_led_o = timeout_reg;
    assign bus_force_ready_o = tif.force_ready;

    // Checks
    nmi_masked_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mask_reg[`MASK_NMI_BIT] |=> !nmi_o)
        else $error("nmi driven while masked");
    nmi_switch_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (switch_s && !mask_reg[`MASK_NMI_BIT]) |=> nmi_o)
        else $error("switch did not raise nmi");
    nmi_romem_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (romem_s && !mask_reg[`MASK_NMI_BIT]) |=> nmi_o)
        else $error("rom pin did not raise nmi");
    nmi_host_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(host_nmi_s) |-> nmi_status[`NMI_ST_HOST_BIT])
        else $error("host nmi not in status");
    first_maskable_irq_mask_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mask_reg[`MASK_FIRST_MASKABLE_IRQ_BIT] |=> !first_maskable_irq_o)
        else $error("first_maskable_irq driven while masked");
    first_maskable_irq_host_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (host_first_maskable_irq_s && !mask_reg[`MASK_FIRST_MASKABLE_IRQ_BIT]) |=> first_maskable_irq_o)
        else $error("host did not raise first_maskable_irq");
    second_maskable_irq_timer_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (timer_s && second_maskable_irq_sel_reg[`SECOND_MASKABLE_IRQ_SEL_TIMER_BIT] && !mask_reg[`MASK_SECOND_MASKABLE_IRQ_BIT]) |=> second_maskable_irq_o)
        else $error("timer did not raise second_maskable_irq");
    sequence unmask_s;
        wr_mask && !wdata_i[`MASK_NMI_BIT] && (|nmi_status);
    endsequence
    pending_unmask_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        unmask_s ##1 (|nmi_status) |=> nmi_o)
        else $error("pending nmi lost on unmask");
    led_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (wr_to_clear && !tif.timeout_pulse) |=> !timeout_indicator_led_o && !second_maskable_irq_status[`SECOND_MASKABLE_IRQ_SEL_TIMEOUT_BIT]
        && !nmi_status[`NMI_SEL_TIMEOUT_BIT])
        else $error("clear did not drop led");
    timeout_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        tif.timeout_pulse |=> timeout_indicator_led_o)
        else $error("timeout did not light led");
endmodule : board_interrupt_router

// *** hdl/bus_timeout.sv ***
`timescale 1ns/1ps
`include "irq_router_map.svh"
module bus_timeout
    import irq_router_pkg::*;
#(
    parameter int LIMIT = `TIMEOUT_CLOCKS
) (
    input wire logic clk_i,   // System clock
    input wire logic rstn_i,  // Sync reset, active low
    timeout_if.watch tif      // Cycle watch link
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    bus_state_t state_reg;
    bus_state_t state_next;
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    wire expire = (state_reg == BUS_BUSY) && (count_reg == LAST);

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            BUS_IDLE: begin
                count_next = '0;
                if (tif.cycle_busy) begin
                    state_next = BUS_BUSY;
                end
            end
            BUS_BUSY: begin
                if (!tif.cycle_busy) begin
                    state_next = BUS_IDLE;
                    count_next = '0;
                end else if (expire) begin
                    state_next = BUS_TIMED;
                end else begin
                    count_next = count_reg + CW'(1);
                end
            end
            BUS_TIMED: begin
                // Hold ready until the cycle ends, so the CPU sees it reliably
                count_next = '0;
                if (!tif.cycle_busy) begin
                    state_next = BUS_IDLE;
                end
            end
            default: begin
                state_next = BUS_IDLE;
                count_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_reg <= BUS_IDLE;
            count_reg <= '0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    assign tif.force_ready = (state_reg == BUS_TIMED);
    assign tif.timeout_pulse = expire && tif.cycle_busy;

    // The last counted busy clock must hand over to forced completion on the next edge
    busy_limit_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_reg == BUS_BUSY && count_reg == LAST && tif.cycle_busy) |=> tif.force_ready)
        else $error("timeout not forced after limit");
endmodule : bus_timeout

// *** hdl/irq_router_map.svh ***
`ifndef IRQ_ROUTER_MAP_SVH
`define IRQ_ROUTER_MAP_SVH

// Register byte addresses on the plain port (byte address = 4 x index)
`define REG_MASK_ADDR      8'h00
`define REG_NMI_SEL_ADDR   8'h04
`define REG_FIRST_MASKABLE_IRQ_SEL_ADDR  8'h08
`define REG_SECOND_MASKABLE_IRQ_SEL_ADDR  8'h0c
`define REG_NMI_STAT_ADDR  8'h10
`define REG_FIRST_MASKABLE_IRQ_STAT_ADDR 8'h14
`define REG_SECOND_MASKABLE_IRQ_STAT_ADDR 8'h18
`define REG_TO_CLEAR_ADDR  8'h1c

// Mask port fields
`define MASK_NMI_BIT  0
`define MASK_FIRST_MASKABLE_IRQ_BIT 1
`define MASK_SECOND_MASKABLE_IRQ_BIT 2

// NMI select / status fields
`define NMI_SEL_SERIAL_BIT  0
`define NMI_SEL_TIMER_BIT   1
`define NMI_SEL_TIMEOUT_BIT 2
`define NMI_SEL_EXP_BIT     3
`define NMI_ST_ROMEM_BIT    4
`define NMI_ST_HOST_BIT     5
`define NMI_ST_SWITCH_BIT   6

// FIRST_MASKABLE_IRQ select / status fields
`define FIRST_MASKABLE_IRQ_SEL_CH1_BIT   0
`define FIRST_MASKABLE_IRQ_SEL_PRN_BIT   1
`define FIRST_MASKABLE_IRQ_ST_HOST_BIT   2

// SECOND_MASKABLE_IRQ select / status fields
`define SECOND_MASKABLE_IRQ_SEL_TIMER_BIT   0
`define SECOND_MASKABLE_IRQ_SEL_TIMEOUT_BIT 1

// Reset values
`define MASK_RESET     8'h00
`define NMI_SEL_RESET  8'h00
`define FIRST_MASKABLE_IRQ_SEL_RESET 8'h00
`define SECOND_MASKABLE_IRQ_SEL_RESET 8'h00

// Bus timeout: 1024 clocks of one cycle in progress
`define TIMEOUT_CLOCKS 1024

`endif

// *** hdl/irq_router_pkg.sv ***
package irq_router_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_BUSY = 2'b01,
        BUS_TIMED = 2'b11
    } bus_state_t;
endpackage : irq_router_pkg

// *** hdl/timeout_if.sv ***
`timescale 1ns/1ps
interface timeout_if;
    logic cycle_busy;
    logic clear;
    logic force_ready;
    logic timeout_pulse;
    modport watch (input cycle_busy, input clear, output force_ready, output timeout_pulse);
    modport user (output cycle_busy, output clear, input force_ready, input timeout_pulse);
endinterface : timeout_if

// *** tb/bus_cycle_model.sv ***
`timescale 1ns/1ps
module bus_cycle_model (
    input wire logic clk_i,         // System clock
    input wire logic rstn_i,        // Sync reset, active low
    input wire logic start_i,       // Begin one external bus cycle
    input wire logic force_ready_i, // Forced completion from the router
    output logic busy_o             // Cycle in progress
);
    // Models a slave that never answers, so only forced completion ends the cycle
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            busy_o <= 1'b0;
        end else if (start_i) begin
            busy_o <= 1'b1;
        end else if (force_ready_i) begin
            busy_o <= 1'b0;
        end
    end
endmodule : bus_cycle_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "irq_router_map.svh"
module testbench;
    import irq_router_pkg::*;
    localparam int LIMIT = 8;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic ch1 = 1'b0, prn = 1'b0, tmr = 1'b0, exp_n = 1'b1, rom = 1'b0, hnmi = 1'b0, hint0 = 1'b0, sw = 1'b0;
    logic start = 1'b0;
    logic [7:0] rdata_o;
    logic busy, force_ready, nmi, first_maskable_irq, second_maskable_irq, exp_pin, led;
    int errors = 0;
    int tests_run = 0;

    always #25 clk_i = ~clk_i;

    bus_cycle_model partner (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start), .force_ready_i(force_ready),
        .busy_o(busy));

    board_interrupt_router #(.TIMEOUT_LIMIT(LIMIT)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_channel_one_i(ch1),
        .printer_irq_i(prn), .timer_irq_i(tmr), .expansion_connector_irq_n_i(exp_n),
        .rom_emulation_connector_nmi_i(rom), .host_nmi_i(hnmi), .host_first_maskable_irq_i(hint0),
        .nonmaskable_push_switch_i(sw), .bus_cycle_busy_i(busy), .bus_force_ready_o(force_ready),
        .nmi_o(nmi), .first_maskable_irq_o(first_maskable_irq), .second_maskable_irq_o(second_maskable_irq),
        .expansion_irq_pin_o(exp_pin), .timeout_indicator_led_o(led));

    task automatic complete_run;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_byte(input reg_byte_t got, input reg_byte_t exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_byte

    // Outputs packed as {nmi, first_maskable_irq, second_maskable_irq} in the low bits
    function automatic reg_byte_t outs();
        return {5'h00, nmi, first_maskable_irq, second_maskable_irq};
    endfunction : outs

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd_check(input logic [7:0] a, input reg_byte_t exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check_byte(rdata_o, exp);
    endtask : rd_check

    // Sources pass a 2-stage synchroniser, so allow a little over the 3-edge path
    task automatic settle;
        repeat (5) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic drive_src(input int j, input logic v);
        @(posedge clk_i);
        case (j)
            0: ch1 <= v;
            1: prn <= v;
            2: tmr <= v;
            3: exp_n <= ~v;
            4: hint0 <= v;
            5: rom <= v;
            6: hnmi <= v;
            default: sw <= v;
        endcase
    endtask : drive_src

    initial begin
        reg_byte_t sel;
        int n;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1;
        check_byte(outs(), 8'h00);
        rd_check(`REG_MASK_ADDR, `MASK_RESET);
        rd_check(`REG_NMI_SEL_ADDR, `NMI_SEL_RESET);
        rd_check(`REG_FIRST_MASKABLE_IRQ_SEL_ADDR, `FIRST_MASKABLE_IRQ_SEL_RESET);
        rd_check(`REG_SECOND_MASKABLE_IRQ_SEL_ADDR, `SECOND_MASKABLE_IRQ_SEL_RESET);
        for (int i = 0; i < 3; i++) begin
            drive_src(5 + i, 1'b1);
            settle();
            check_byte(outs(), 8'h04);
            rd_check(`REG_NMI_STAT_ADDR, 8'h10 << i);
            drive_src(5 + i, 1'b0);
        end
        for (int j = 0; j < 4; j++) begin
            sel = (j == 2) ? 8'h02 : ((j == 3) ? 8'h08 : 8'h01);
            drive_src(j, 1'b1);
            settle();
            check_byte(outs(), 8'h00);
            wr(`REG_NMI_SEL_ADDR, sel);
            settle();
            check_byte(outs(), 8'h04);
            rd_check(`REG_NMI_STAT_ADDR, sel);
            check_bit(exp_pin, j == 3);
            drive_src(j, 1'b0);
            wr(`REG_NMI_SEL_ADDR, 8'h00);
        end
        wr(`REG_MASK_ADDR, 8'h01);
        drive_src(7, 1'b1);
        settle();
        check_byte(outs(), 8'h00);
        rd_check(`REG_NMI_STAT_ADDR, 8'h40);
        wr(`REG_MASK_ADDR, 8'h00);
        settle();
        check_byte(outs(), 8'h04);
        // Handler order: mask, read status, clear the source, unmask
        wr(`REG_MASK_ADDR, 8'h01);
        settle();
        check_byte(outs(), 8'h00);
        rd_check(`REG_NMI_STAT_ADDR, 8'h40);
        drive_src(7, 1'b0);
        wr(`REG_MASK_ADDR, 8'h00);
        settle();
        check_byte(outs(), 8'h00);
        for (int j = 0; j < 3; j++) begin
            sel = 8'h01 << j;
            wr(`REG_FIRST_MASKABLE_IRQ_SEL_ADDR, (j < 2) ? sel : 8'h00);
            drive_src((j < 2) ? j : 4, 1'b1);
            settle();
            check_byte(outs(), 8'h02);
            rd_check(`REG_FIRST_MASKABLE_IRQ_STAT_ADDR, sel);
            wr(`REG_MASK_ADDR, 8'h02);
            settle();
            check_byte(outs(), 8'h00);
            drive_src((j < 2) ? j : 4, 1'b0);
            wr(`REG_MASK_ADDR, 8'h00);
        end
        wr(`REG_SECOND_MASKABLE_IRQ_SEL_ADDR, 8'h01);
        drive_src(2, 1'b1);
        settle();
        check_byte(outs(), 8'h01);
        rd_check(`REG_SECOND_MASKABLE_IRQ_STAT_ADDR, 8'h01);
        wr(`REG_MASK_ADDR, 8'h04);
        settle();
        check_byte(outs(), 8'h00);
        drive_src(2, 1'b0);
        wr(`REG_MASK_ADDR, 8'h00);
        wr(`REG_NMI_SEL_ADDR, 8'h04);
        wr(`REG_SECOND_MASKABLE_IRQ_SEL_ADDR, 8'h02);
        @(posedge clk_i);
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        repeat (LIMIT - 1) @(posedge clk_i);
        #1;
        check_bit(force_ready, 1'b0);
        n = 0;
        while (force_ready !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check_bit(force_ready, 1'b1);
        settle();
        check_bit(busy, 1'b0);
        check_bit(led, 1'b1);
        check_byte(outs(), 8'h05);
        rd_check(`REG_TO_CLEAR_ADDR, 8'h01);
        rd_check(`REG_NMI_STAT_ADDR, 8'h04);
        rd_check(`REG_SECOND_MASKABLE_IRQ_STAT_ADDR, 8'h02);
        wr(`REG_TO_CLEAR_ADDR, 8'h5a);
        settle();
        check_bit(led, 1'b0);
        check_byte(outs(), 8'h00);
        wr(8'h20, 8'hff);
        rd_check(8'h20, 8'h00);
        rd_check(`REG_MASK_ADDR, 8'h00);
        // Mid-run reset must drop masks set by software
        wr(`REG_MASK_ADDR, 8'h07);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd_check(`REG_MASK_ADDR, `MASK_RESET);
        complete_run();
    end
endmodule : testbench
